// >>> core/jog_if.sv
// Signals between the sequencer and its jog key handler
`timescale 1ns/1ps
interface jog_if;
    logic key_mode; // Clean mode/set key level
    logic key_data; // Clean data key level
    logic key_up; // Clean up key level
    logic key_down; // Clean down key level
    logic [7:0] sys_check_select; // System check selection
    logic jog_on; // Jog operation enabled
    logic jog_servo; // Servo requested by jog
    logic jog_fwd; // Forward jog requested
    logic jog_rev; // Reverse jog requested
    modport seq (output key_mode, key_data, key_up, key_down,
                 output sys_check_select,
                 input jog_on, jog_servo, jog_fwd, jog_rev);
    modport jog (input key_mode, key_data, key_up, key_down,
                 input sys_check_select,
                 output jog_on, jog_servo, jog_fwd, jog_rev);
endinterface : jog_if

// >>> core/jog_keys.sv
// Jog key handler: enable toggle, servo toggle and direction
`timescale 1ns/1ps
`include "sbj_params.svh"
module jog_keys (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Link to the sequencer
    jog_if.jog jif
);
    logic mode_q; // Previous mode key level
    logic data_q; // Previous data key level
    logic jog_on_q; // Jog operation enabled
    logic servo_q; // Servo requested by jog
    logic jog_ok; // Selection permits jog

    assign jog_ok = (jif.sys_check_select == `SYS_CHECK_JOG);

    // Key history for press detection
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_q <= 1'b0;
            data_q <= 1'b0;
        end else begin
            mode_q <= jif.key_mode;
            data_q <= jif.key_data;
        end
    end

    // Jog enable; leaving the jog selection forces it off
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            jog_on_q <= 1'b0;
        end else if (!jog_ok) begin
            jog_on_q <= 1'b0;
        end else if (jif.key_mode && !mode_q) begin
            jog_on_q <= !jog_on_q;
        end
    end

    // Servo toggle, only meaningful while jog is on
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            servo_q <= 1'b0;
        end else if (!jog_on_q) begin
            servo_q <= 1'b0;
        end else if (jif.key_data && !data_q) begin
            servo_q <= !servo_q;
        end
    end

    assign jif.jog_on = jog_on_q;
    assign jif.jog_servo = servo_q;
    // Both keys held cancel each other out
    assign jif.jog_fwd = servo_q && jif.key_up && !jif.key_down;
    assign jif.jog_rev = servo_q && jif.key_down && !jif.key_up;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    AST_JOG_GATE: assert property ($rose(jog_on_q) |-> $past(jog_ok))
        else $error("jog enabled outside jog selection");
    AST_JOG_TOGGLE: assert property (jog_ok && jif.key_mode && !mode_q
        |=> jog_on_q != $past(jog_on_q))
        else $error("mode key press did not toggle jog");
    AST_SERVO_TOGGLE: assert property (jog_on_q && jog_ok && jif.key_data
        && !data_q |=> servo_q != $past(servo_q))
        else $error("data key press did not toggle servo");
    AST_JOG_DIR: assert property (jif.jog_fwd |-> servo_q && jif.key_up
        && !jif.jog_rev)
        else $error("forward jog without servo or up key");
    COV_JOG_FWD: cover property (jog_on_q ##[1:50] jif.jog_fwd);
endmodule : jog_keys

// >>> core/sbj_params.svh
// Constants for the brake interlock and jog sequencer
`ifndef SBJ_PARAMS_SVH
`define SBJ_PARAMS_SVH
// Clock and timebase
`define CLK_FREQ_KHZ 50000
`define TICK_PERIOD_MS 10
`define TICK_CYCLES (`TICK_PERIOD_MS * `CLK_FREQ_KHZ)
// Coast time before the dynamic brake acts, in ms and in ticks
`define DB_DELAY_MS 10
`define DB_TICKS (`DB_DELAY_MS / `TICK_PERIOD_MS)
// Parameter numbers used by the parameter unit write port
`define PRM_SYS_CHECK 8'h00
`define PRM_JOG_SPEED 8'h10
`define PRM_PRE_OFF 8'h12
`define PRM_SPEED_THR 8'h15
`define PRM_POST_OFF 8'h16
// Reset values
`define RST_SYS_CHECK 8'h00
`define RST_JOG_SPEED 16'h01F4
`define RST_PRE_OFF 16'h0000
`define RST_SPEED_THR 16'h0064
`define RST_POST_OFF 16'h0032
// Legal ranges
`define MIN_PRE_OFF 16'h0000
`define MAX_PRE_OFF 16'h0032
`define MIN_POST_OFF 16'h000A
`define MAX_POST_OFF 16'h0064
`define MIN_SPEED 16'h0000
`define MAX_SPEED 16'h1194
// Selection value that permits jog
`define SYS_CHECK_JOG 8'h00
`endif

// >>> core/sbj_pkg.sv
// Types shared by the brake interlock and jog sequencer
package sbj_pkg;
    // Servo power and brake sequence states
    typedef enum logic [2:0] {
        ST_INIT,
        ST_OFF,
        ST_ON,
        ST_PRE_OFF,
        ST_POST_OFF
    } seq_state_e;
    // Tick counter and short timer types
    typedef logic [19:0] tick_cnt_t;
    typedef logic [7:0] tmr_t;
endpackage : sbj_pkg

// >>> core/servo_brake_interlock_jog.sv
// Servo on/off sequencer with brake interlock and jog operation
//
// Functional notes
// - Drop brake, wait pre delay, then cut power
// - Post-off wait bounds brake hold after power-off
// - Drop brake on low speed or wait expiry
// - Dynamic brake on the second tick after power removal
// - Run command on enters servo-on, powers motor
// - After initialization enter status display mode
// - Jog allowed only with selection value 00
// - Mode key toggles jog; commands need jog
// - Data key toggles servo during jog
// - Up runs forward, down runs reverse
// - Jog runs at programmable jog speed
`timescale 1ns/1ps
`include "sbj_params.svh"
module servo_brake_interlock_jog #(
    parameter int TICK_CYCLES = `TICK_CYCLES // Cycles per 10 ms tick
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Host and drive status inputs
    input wire logic i_run, // Run command pin
    input wire logic i_error, // Drive error, same clock
    input wire logic [15:0] i_motor_speed, // Speed magnitude, r/min
    // Parameter unit keys (pins)
    input wire logic i_key_mode,
    input wire logic i_key_data,
    input wire logic i_key_up,
    input wire logic i_key_down,
    // Parameter unit write port
    input wire logic i_prm_wr,
    input wire logic [7:0] i_prm_num,
    input wire logic [15:0] i_prm_data,
    // Power stage and brake
    output logic o_motor_power,
    output logic o_brake_release_output,
    output logic o_dyn_brake,
    // Status and jog motion command
    output logic o_status_display,
    output logic o_jog_active,
    output logic o_jog_fwd,
    output logic o_jog_rev,
    output logic [15:0] o_speed_cmd
);
    logic rst1_q; // Reset release stage one
    logic rst_n; // Synchronised reset
    logic [4:0] s1_q; // Pin sync stage one
    logic [4:0] s2_q; // Pin sync stage two
    logic [4:0] s3_q; // Pin sync stage three
    logic [4:0] pin_q; // Clean pin levels
    logic [7:0] sys_check_q; // System check selection
    logic [15:0] jog_speed_q; // Jog speed setting
    logic [15:0] pre_off_q; // Pre-servo-off delay, ticks
    logic [15:0] thr_q; // Brake speed threshold
    logic [15:0] post_off_q; // Post-servo-off wait, ticks
    sbj_pkg::tick_cnt_t div_q; // Tick divider
    logic tick; // One cycle each 10 ms
    sbj_pkg::tmr_t pre_tmr_q; // Ticks spent in pre-off
    sbj_pkg::tmr_t off_tmr_q; // Ticks since power removal
    sbj_pkg::seq_state_e state_q; // Sequence state
    logic servo_req; // Servo wanted by run pin or jog
    logic slow; // Motor under brake threshold
    jog_if jif ();

    // Saturating timer increment, avoids wrap on long idles
    function automatic sbj_pkg::tmr_t sat_inc(input sbj_pkg::tmr_t v);
        sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    endfunction : sat_inc

    // Clamp a written value into its legal range
    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst1_q <= 1'b1;
            rst_n <= rst1_q;
        end
    end

    // Three-flop pin synchroniser; level accepted when stages two and three agree
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
            pin_q <= 5'h00;
        end else begin
            s1_q <= {i_run, i_key_mode, i_key_data, i_key_up, i_key_down};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s3_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
        end
    end

    assign jif.key_mode = pin_q[3];
    assign jif.key_data = pin_q[2];
    assign jif.key_up = pin_q[1];
    assign jif.key_down = pin_q[0];
    assign jif.sys_check_select = sys_check_q;

    jog_keys u_jog (
        .i_mclk(i_mclk),
        .i_rst_b(rst_n),
        .jif(jif)
    );

    // Parameter store; out-of-range writes are clamped, not refused
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            sys_check_q <= `RST_SYS_CHECK;
            jog_speed_q <= `RST_JOG_SPEED;
            pre_off_q <= `RST_PRE_OFF;
            thr_q <= `RST_SPEED_THR;
            post_off_q <= `RST_POST_OFF;
        end else if (i_prm_wr) begin
            unique case (i_prm_num)
                `PRM_SYS_CHECK: sys_check_q <= i_prm_data[7:0];
                `PRM_JOG_SPEED: jog_speed_q <=
                    clamp(i_prm_data, `MIN_SPEED, `MAX_SPEED);
                `PRM_PRE_OFF: pre_off_q <=
                    clamp(i_prm_data, `MIN_PRE_OFF, `MAX_PRE_OFF);
                `PRM_SPEED_THR: thr_q <=
                    clamp(i_prm_data, `MIN_SPEED, `MAX_SPEED);
                `PRM_POST_OFF: post_off_q <=
                    clamp(i_prm_data, `MIN_POST_OFF, `MAX_POST_OFF);
                default: ;
            endcase
        end
    end

    // Free-running 10 ms timebase
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 20'h00001;
        end
    end
    assign tick = (div_q == 20'(TICK_CYCLES - 1));

    assign servo_req = pin_q[4] || (jif.jog_on && jif.jog_servo);
    assign slow = (i_motor_speed < thr_q);

    // Pre-off timer runs only in its state; first tick may be partial
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_tmr_q <= 8'h00;
        end else if (state_q != sbj_pkg::ST_PRE_OFF) begin
            pre_tmr_q <= 8'h00;
        end else if (tick) begin
            pre_tmr_q <= sat_inc(pre_tmr_q);
        end
    end

    // Time since power removal drives dynamic brake and post wait
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            off_tmr_q <= 8'h00;
            o_dyn_brake <= 1'b0;
        end else begin
            if (o_motor_power) begin
                off_tmr_q <= 8'h00;
            end else if (tick) begin
                off_tmr_q <= sat_inc(off_tmr_q);
            end
            // Motor coasts a whole tick at least; first tick may be partial
            o_dyn_brake <= !o_motor_power &&
                (off_tmr_q > 8'(`DB_TICKS));
        end
    end

    // Main sequence: power, brake and status display
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sbj_pkg::ST_INIT;
            o_motor_power <= 1'b0;
            o_brake_release_output <= 1'b0;
            o_status_display <= 1'b0;
        end else begin
            unique case (state_q)
                sbj_pkg::ST_INIT: begin
                    state_q <= sbj_pkg::ST_OFF;
                    o_status_display <= 1'b1;
                end
                sbj_pkg::ST_OFF: begin
                    if (servo_req && !i_error) begin
                        state_q <= sbj_pkg::ST_ON;
                        o_motor_power <= 1'b1;
                        o_brake_release_output <= 1'b1;
                    end
                end
                sbj_pkg::ST_ON: begin
                    // Running motor: cut power first, brake later
                    if (i_error || (!servo_req && !slow)) begin
                        state_q <= sbj_pkg::ST_POST_OFF;
                        o_motor_power <= 1'b0;
                    end else if (!servo_req) begin
                        state_q <= sbj_pkg::ST_PRE_OFF;
                        o_brake_release_output <= 1'b0;
                    end
                end
                sbj_pkg::ST_PRE_OFF: begin
                    // Error cuts power at once; brake is already dropped
                    if (i_error || (16'(pre_tmr_q) >= pre_off_q)) begin
                        state_q <= sbj_pkg::ST_OFF;
                        o_motor_power <= 1'b0;
                    end
                end
                sbj_pkg::ST_POST_OFF: begin
                    if (slow || (16'(off_tmr_q) >= post_off_q)) begin
                        state_q <= sbj_pkg::ST_OFF;
                        o_brake_release_output <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Jog motion command; only passes while jog runs the servo
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_jog_active <= 1'b0;
            o_jog_fwd <= 1'b0;
            o_jog_rev <= 1'b0;
            o_speed_cmd <= 16'h0000;
        end else begin
            o_jog_active <= jif.jog_on;
            o_jog_fwd <= (state_q == sbj_pkg::ST_ON) && jif.jog_fwd;
            o_jog_rev <= (state_q == sbj_pkg::ST_ON) && jif.jog_rev;
            o_speed_cmd <= ((state_q == sbj_pkg::ST_ON) &&
                (jif.jog_fwd || jif.jog_rev)) ? jog_speed_q : 16'h0000;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    AST_PRE_HOLD: assert property (state_q == sbj_pkg::ST_PRE_OFF
        |-> o_motor_power && !o_brake_release_output)
        else $error("pre-off must hold power with brake dropped");
    AST_PRE_END: assert property (state_q == sbj_pkg::ST_PRE_OFF &&
        16'(pre_tmr_q) >= pre_off_q |=> !o_motor_power)
        else $error("power not cut after pre-off delay");
    AST_POST_WAIT: assert property (state_q == sbj_pkg::ST_POST_OFF &&
        16'(off_tmr_q) >= post_off_q |=> !o_brake_release_output)
        else $error("brake held past post-off wait");
    AST_SLOW_DROP: assert property (state_q == sbj_pkg::ST_POST_OFF &&
        slow |=> !o_brake_release_output && !o_motor_power)
        else $error("brake not dropped at low speed");
    AST_DB: assert property ($fell(o_motor_power) |-> !o_dyn_brake ##1
        !o_dyn_brake)
        else $error("dynamic brake engaged too early");
    AST_RUN_ON: assert property (state_q == sbj_pkg::ST_OFF && servo_req
        && !i_error |=> o_motor_power && o_brake_release_output)
        else $error("servo request did not power motor");
    AST_DISPLAY: assert property ($past(state_q) == sbj_pkg::ST_INIT
        && state_q == sbj_pkg::ST_OFF |-> o_status_display)
        else $error("status display not entered after init");
    AST_ERR_OFF: assert property (state_q == sbj_pkg::ST_ON && i_error
        |=> !o_motor_power ##1 state_q != sbj_pkg::ST_ON)
        else $error("error did not start servo-off");
    AST_BRAKE_ON: assert property (state_q == sbj_pkg::ST_ON
        |-> o_brake_release_output && o_motor_power)
        else $error("brake not released while servo on");
    AST_JOG_SPEED: assert property (o_jog_fwd || o_jog_rev
        |-> o_speed_cmd == $past(jog_speed_q))
        else $error("jog speed command mismatch");

    COV_ON: cover property (state_q == sbj_pkg::ST_ON);
    COV_PRE: cover property (state_q == sbj_pkg::ST_PRE_OFF ##[1:20]
        state_q == sbj_pkg::ST_OFF);
    COV_POST: cover property (state_q == sbj_pkg::ST_POST_OFF ##[1:20]
        state_q == sbj_pkg::ST_OFF);
    COV_DB: cover property ($rose(o_dyn_brake));
endmodule : servo_brake_interlock_jog

// >>> tb/sbj_host_model.sv
// Host controller and brake switch model facing the sequencer
`timescale 1ns/1ps
module sbj_host_model #(
    parameter int HOLD_CYCLES = 200 // Brake clear allowance in cycles
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Bench requests
    input wire logic i_run_req,
    input wire logic [15:0] i_speed_tgt,
    // Drive outputs watched by the host
    input wire logic i_power,
    input wire logic i_brake_rel,
    // Pins toward the drive
    output logic o_run,
    output logic [15:0] o_motor_speed,
    output logic o_cmd_ok
);
    int hold_q; // Cycles since the brake was released

    // Motion is withheld until the brake has had time to clear
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_q <= 0;
            o_run <= 1'b0;
            o_motor_speed <= 16'h0000;
        end else begin
            o_run <= i_run_req;
            if (!i_brake_rel) begin
                hold_q <= 0;
            end else if (hold_q < HOLD_CYCLES) begin
                hold_q <= hold_q + 1;
            end
            // An unpowered motor keeps turning: residual rotation
            if (o_cmd_ok || !i_power) begin
                o_motor_speed <= i_speed_tgt;
            end else begin
                o_motor_speed <= 16'h0000;
            end
        end
    end
    assign o_cmd_ok = (hold_q >= HOLD_CYCLES);
endmodule : sbj_host_model

// >>> tb/servo_brake_interlock_jog_test.sv
// Self-checking bench for the brake interlock and jog sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("wrong value at %0t: output mismatch", $time); \
    end \
end
module servo_brake_interlock_jog_test;
    localparam int T = 10; // Short tick keeps the run brief
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_error = 1'b0;
    logic [3:0] keys = 4'h0; // Mode, data, up, down
    logic i_prm_wr = 1'b0;
    logic [7:0] i_prm_num = 8'h00;
    logic [15:0] i_prm_data = 16'h0000;
    logic run_req = 1'b0;
    logic [15:0] spd_tgt = 16'h0000;
    logic i_run, o_motor_power, o_brake_release_output, o_dyn_brake;
    logic o_status_display, o_jog_active, o_jog_fwd, o_jog_rev, cmd_ok;
    logic [15:0] i_motor_speed, o_speed_cmd, thr, js;
    logic [20:0] exp_q[$]; // Expected output changes, oldest first
    logic [20:0] prev_v = 21'h000000;
    logic armed = 1'b0;
    logic [15:0] pre_set[3] = '{16'h003C, 16'h000A, 16'h0000};
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'h4dd34145;
    int n1, n2, d, w;
    wire [20:0] cur_v = {o_motor_power, o_brake_release_output,
                         o_jog_active, o_jog_fwd, o_jog_rev, o_speed_cmd};

    servo_brake_interlock_jog #(.TICK_CYCLES(T)) dut (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_run(i_run),
        .i_error(i_error), .i_motor_speed(i_motor_speed),
        .i_key_mode(keys[0]), .i_key_data(keys[1]),
        .i_key_up(keys[2]), .i_key_down(keys[3]),
        .i_prm_wr(i_prm_wr), .i_prm_num(i_prm_num),
        .i_prm_data(i_prm_data), .o_motor_power(o_motor_power),
        .o_brake_release_output(o_brake_release_output),
        .o_dyn_brake(o_dyn_brake), .o_status_display(o_status_display),
        .o_jog_active(o_jog_active), .o_jog_fwd(o_jog_fwd),
        .o_jog_rev(o_jog_rev), .o_speed_cmd(o_speed_cmd));

    sbj_host_model #(.HOLD_CYCLES(20 * T)) host (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_run_req(run_req),
        .i_speed_tgt(spd_tgt), .i_power(o_motor_power),
        .i_brake_rel(o_brake_release_output), .o_run(i_run),
        .o_motor_speed(i_motor_speed), .o_cmd_ok(cmd_ok));

    // Free-running 50 MHz clock
    initial begin
        forever #10 i_mclk = ~i_mclk;
    end

    // Each output change consumes the oldest expectation
    always @(posedge i_mclk) begin
        if (armed && cur_v !== prev_v) begin
            if (exp_q.size() == 0) begin
                `CHK(cur_v, prev_v)
            end else begin
                `CHK(cur_v, exp_q.pop_front())
            end
        end
        prev_v <= cur_v;
    end

    // Hang guard, well above the expected run length
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : tick

    task automatic ex(input logic [4:0] fl, input logic [15:0] s);
        exp_q.push_back({fl, s});
    endtask : ex

    // One-cycle write strobe on the parameter port
    task automatic prm(input logic [7:0] num, input logic [15:0] dat);
        @(posedge i_mclk);
        i_prm_wr <= 1'b1;
        i_prm_num <= num;
        i_prm_data <= dat;
        @(posedge i_mclk);
        i_prm_wr <= 1'b0;
    endtask : prm

    // Key held long enough to pass the pin synchroniser
    task automatic press(input logic [3:0] k);
        @(posedge i_mclk);
        keys <= k;
        tick(8);
        keys <= 4'h0;
        tick(8);
    endtask : press

    // Counts edges until brake(0), power(1) or dyn(2) reaches lvl
    task automatic wait_sig(input int sel, input logic lvl,
                            input int maxc, output int n);
        logic [2:0] s;
        n = 0;
        s = {o_dyn_brake, o_motor_power, o_brake_release_output};
        while (s[sel] !== lvl && n < maxc) begin
            @(posedge i_mclk);
            n++;
            s = {o_dyn_brake, o_motor_power, o_brake_release_output};
        end
    endtask : wait_sig

    task automatic drain();
        for (int i = 0; i < 100 && exp_q.size() != 0; i++) begin
            @(posedge i_mclk);
        end
        `CHK(exp_q.size(), 0)
    endtask : drain

    initial begin
        tick(5);
        i_rst_b <= 1'b1;
        tick(6);
        armed = 1'b1;
        `CHK(o_status_display, 1'b1)
        `CHK(cur_v, 21'h000000)
        tick(2 * T + 4);
        `CHK(o_dyn_brake, 1'b1)
        // Slow stop: brake first, power after the pre-off delay
        foreach (pre_set[i]) begin
            prm(8'h12, pre_set[i]);
            d = (pre_set[i] > 16'h0032) ? 50 : int'(pre_set[i]);
            ex(5'h18, 16'h0000);
            run_req <= 1'b1;
            drain();
            ex(5'h10, 16'h0000);
            ex(5'h00, 16'h0000);
            run_req <= 1'b0;
            wait_sig(0, 1'b0, 20, n1);
            wait_sig(1, 1'b0, d * T + 20, n2);
            `CHK(n2 >= (d == 0 ? 1 : (d - 1) * T) && n2 <= d * T + 2, 1'b1)
            wait_sig(2, 1'b1, 2 * T + 20, n1);
            `CHK(n1 >= T + 1 && n1 <= 2 * T + 3, 1'b1)
            drain();
        end
        // Fast stop: power first, brake on wait expiry or low speed
        thr = 16'(200 + $unsigned($random(seed)) % 3800);
        prm(8'h15, thr);
        prm(8'h12, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            prm(8'h16, (i == 1) ? 16'h0014 : 16'h0005);
            w = (i == 1) ? 20 : 10; // A 5 is raised to the floor of 10
            ex(5'h18, 16'h0000);
            run_req <= 1'b1;
            drain();
            for (n1 = 0; n1 < 400 && cmd_ok !== 1'b1; n1++) tick(1);
            `CHK(cmd_ok, 1'b1)
            spd_tgt <= thr + 16'(1 + $unsigned($random(seed)) % 200);
            tick(4);
            ex(5'h08, 16'h0000);
            ex(5'h00, 16'h0000);
            run_req <= 1'b0;
            wait_sig(1, 1'b0, 20, n1);
            if (i == 1) begin
                tick(30);
                spd_tgt <= thr - 16'h0001;
                wait_sig(0, 1'b0, 10, n2);
                `CHK(n2 <= 5, 1'b1)
            end else begin
                wait_sig(0, 1'b0, w * T + 20, n2);
                `CHK(n2 >= (w - 1) * T && n2 <= w * T + 2, 1'b1)
            end
            drain();
            spd_tgt <= 16'h0000;
            tick(4);
        end
        // Error stops the servo and blocks a standing run command
        ex(5'h18, 16'h0000);
        run_req <= 1'b1;
        drain();
        ex(5'h08, 16'h0000);
        ex(5'h00, 16'h0000);
        i_error <= 1'b1;
        drain();
        tick(40);
        ex(5'h18, 16'h0000);
        i_error <= 1'b0;
        drain();
        ex(5'h10, 16'h0000);
        ex(5'h00, 16'h0000);
        run_req <= 1'b0;
        drain();
        // Error during a long pre-off wait cuts power at once
        prm(8'h12, 16'h0032);
        ex(5'h18, 16'h0000);
        run_req <= 1'b1;
        drain();
        ex(5'h10, 16'h0000);
        ex(5'h00, 16'h0000);
        run_req <= 1'b0;
        wait_sig(0, 1'b0, 20, n1);
        i_error <= 1'b1;
        wait_sig(1, 1'b0, 20, n2);
        `CHK(n2 <= 3, 1'b1)
        i_error <= 1'b0;
        prm(8'h12, 16'h0000);
        drain();
        // Jog: selection gate, toggles, directions, speed
        js = 16'($unsigned($random(seed)) % 4501);
        prm(8'h10, js);
        prm(8'h00, 16'h0005);
        press(4'h1);
        prm(8'h00, 16'h0000);
        ex(5'h04, 16'h0000);
        press(4'h1);
        drain();
        press(4'h4);
        ex(5'h1C, 16'h0000);
        press(4'h2);
        drain();
        for (int k = 2; k < 4; k++) begin
            ex((k == 2) ? 5'h1E : 5'h1D, js);
            ex(5'h1C, 16'h0000);
            press(4'(1 << k));
            drain();
        end
        press(4'hC);
        ex(5'h14, 16'h0000);
        ex(5'h04, 16'h0000);
        press(4'h2);
        drain();
        ex(5'h00, 16'h0000);
        prm(8'h00, 16'h0005);
        drain();
        press(4'h4);
        drain();
        final_report();
    end
endmodule : servo_brake_interlock_jog_test
